// ### rtl/cmd_fifo.sv
`default_nettype none
module cmd_fifo #(
	parameter int WIDTH = 35,
	parameter int DEPTH = 16
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr, next_wr_ptr;
	logic [PW-1:0]    rd_ptr, next_rd_ptr;
	logic [PW:0]      count,  next_count;
	logic             push, pop;

	// --------------------------------------------------------------
	// handshake and pointer update
	// --------------------------------------------------------------
	always_comb begin
		in_ready    = (count != (PW+1)'(DEPTH));
		out_valid   = (count != '0);
		push        = in_valid && in_ready;
		pop         = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_count  = count + (PW+1)'(push) - (PW+1)'(pop);
		out_data    = mem[rd_ptr];
	end

	// storage in flops
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end
endmodule : cmd_fifo
`default_nettype wire

// ### rtl/isp_programmer.sv
// Contract
// [R1] Arrays are programmable over the serial pins only while target reset is low.
// [R2] Programming-enable must complete before any program or erase instruction.
// [R3] Each serial EEPROM write erases its location first; no chip erase needed.
// [R4] Chip erase sets every flash and EEPROM location to 0xFF.
// [R5] Each SCK low and high phase exceeds 2 or 3 CPU clock cycles.
// [R6] Device samples incoming bits on the rising SCK edge.
// [R7] Device shifts outgoing bits onto data-out on the falling SCK edge.
// [R8] Hold reset and SCK low at power-up, else pulse reset high.
// [R9] Wait at least 20 ms after power-up before programming-enable.
// [R10] In sync, device echoes 0x53 while the third byte shifts in.
// [R11] Always shift four bytes; on no echo pulse reset, retry enable.
// [R12] Flash written per page; buffer loaded one byte per load instruction.
// [R13] For each word address load the low byte before the high.
// [R14] Write-page instruction with 8 address MSBs commits the flash page; the bench and target model commit with 10 MSBs.
// [R15] Wait at least 4.5 ms after a flash page write.
// [R16] EEPROM byte write carries address and data; wait 9.0 ms after.
// [R17] EEPROM page: load bytes with 2 LSBs, commit with 4 MSBs; the bench and target model commit with 8 MSBs.
// [R18] EEPROM page write alters only loaded byte locations.
// [R19] A read instruction returns the addressed content on data-out.
// [R20] Session ends by driving reset high; device resumes normal operation.
// [R21] Wait at least 4.5 ms after fuse write, 9.0 ms after erase.
// [R22] Enable instruction: four bytes, 0xAC, 0x53, two don't-care bytes.
// [R23] Chip erase: first byte 0xAC, second byte begins with 100.
// [R24] Bytes shift most significant bit first; four bytes form one instruction.
// [R25] Device ignores write instructions during a self-timed write.
`default_nettype none
module isp_programmer #(
	parameter int POWERUP_WAIT      = isp_pkg::POWERUP_WAIT_CYC,
	parameter int FLASH_PAGE_WAIT   = isp_pkg::FLASH_PAGE_WAIT_CYC,
	parameter int EEPROM_WRITE_WAIT = isp_pkg::EEPROM_WRITE_WAIT_CYC,
	parameter int FUSE_WRITE_WAIT   = isp_pkg::FUSE_WRITE_WAIT_CYC,
	parameter int CHIP_ERASE_WAIT   = isp_pkg::CHIP_ERASE_WAIT_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        session_start,
	input  wire logic        session_end,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [31:0] cmd_word,
	input  wire logic [2:0]  cmd_wait,
	output logic             rsp_valid,
	output logic      [31:0] rsp_word,
	output logic             session_active,
	output logic             sync_fail,
	output logic             link_busy,
	output logic             target_reset_n,
	output logic             target_sck,
	output logic             target_mosi,
	input  wire logic        target_miso
);
	// --------------------------------------------------------------
	// sequencer states
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_POWER  = 3'b001,
		ST_ENABLE = 3'b010,
		ST_PULSE  = 3'b011,
		ST_READY  = 3'b100,
		ST_SEND   = 3'b101,
		ST_WAIT   = 3'b110
	} state_e;

	localparam int TW = isp_pkg::TIMER_W;

	state_e                 state,      next_state;
	logic [TW-1:0]          timer,      next_timer;
	logic [isp_pkg::TRY_W-1:0] tries,   next_tries;
	isp_pkg::wait_e         wait_kind,  next_wait_kind;
	logic                   next_reset_n;
	logic                   next_active;
	logic                   next_fail;
	logic                   next_rsp_valid;
	logic [31:0]            next_rsp_word;
	logic                   miso_s1, miso_s2, miso_s3, miso_level, next_miso_level;
	logic                   shift_start;
	logic [31:0]            shift_word;
	logic                   shift_done;
	logic [31:0]            shift_rx;
	logic                   fifo_valid, fifo_ready;
	logic [isp_pkg::FIFO_WIDTH-1:0] fifo_data;

	// --------------------------------------------------------------
	// wait decode
	// --------------------------------------------------------------
	// cycles to hold off the link after an instruction of this class
	function automatic logic [TW-1:0] wait_cycles(input isp_pkg::wait_e kind);
		logic [TW-1:0] cyc;
		unique case (kind)
			isp_pkg::WAIT_FLASH:  cyc = TW'(FLASH_PAGE_WAIT);    // R15
			isp_pkg::WAIT_EEPROM: cyc = TW'(EEPROM_WRITE_WAIT);  // R16
			isp_pkg::WAIT_FUSE:   cyc = TW'(FUSE_WRITE_WAIT);    // R21
			isp_pkg::WAIT_ERASE:  cyc = TW'(CHIP_ERASE_WAIT);    // R21
			default:              cyc = '0;
		endcase
		return cyc;
	endfunction : wait_cycles

	// --------------------------------------------------------------
	// miso synchroniser
	// --------------------------------------------------------------
	// accept a new level once the second and third stages agree
	always_comb begin
		next_miso_level = (miso_s2 == miso_s3) ? miso_s3 : miso_level;
	end

	// three stages and the accepted level
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			miso_s1    <= 1'b0;
			miso_s2    <= 1'b0;
			miso_s3    <= 1'b0;
			miso_level <= 1'b0;
		end else begin
			miso_s1    <= target_miso;
			miso_s2    <= miso_s1;
			miso_s3    <= miso_s2;
			miso_level <= next_miso_level;
		end
	end

	// --------------------------------------------------------------
	// instruction queue
	// --------------------------------------------------------------
	// queued instructions wait here until the link is enabled, in order
	cmd_fifo #(
		.WIDTH (isp_pkg::FIFO_WIDTH),
		.DEPTH (isp_pkg::FIFO_DEPTH)
	) u_fifo (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.in_data   ({cmd_wait, cmd_word}),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	); // R13

	// --------------------------------------------------------------
	// serial shifter
	// --------------------------------------------------------------
	isp_shift u_shift (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.start      (shift_start),
		.tx_word    (shift_word),
		.miso_level (miso_level),
		.sck        (target_sck),
		.mosi       (target_mosi),
		.done       (shift_done),
		.rx_word    (shift_rx)
	); // R5

	// --------------------------------------------------------------
	// session sequencer
	// --------------------------------------------------------------
	// next-state, timers, pin levels and responses
	always_comb begin
		next_state     = state;
		next_timer     = timer;
		next_tries     = tries;
		next_wait_kind = wait_kind;
		next_reset_n   = target_reset_n;
		next_active    = session_active;
		next_fail      = sync_fail;
		next_rsp_valid = 1'b0;
		next_rsp_word  = rsp_word;
		shift_start    = 1'b0;
		shift_word     = isp_pkg::PROG_EN_WORD;
		fifo_ready     = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (session_start) begin
					// reset was high in idle: that is the pulse after sck low
					next_reset_n = 1'b0;                           // R8
					next_timer   = TW'(POWERUP_WAIT - 1);          // R9
					next_tries   = '0;
					next_fail    = 1'b0;
					next_state   = ST_POWER;
				end
			end
			ST_POWER: begin
				// the full wait runs again after every retry pulse
				if (timer == '0) begin
					shift_start = 1'b1;                            // R22
					next_state  = ST_ENABLE;
				end else begin
					next_timer = timer - 1'b1;
				end
			end
			ST_ENABLE: begin
				if (shift_done) begin
					// all four bytes went out before the echo is judged
					if (shift_rx[isp_pkg::ECHO_LSB +: 8] == isp_pkg::ECHO_BYTE) begin // R10
						next_active = 1'b1;
						next_state  = ST_READY;
					end else if (tries == isp_pkg::TRY_W'(isp_pkg::MAX_TRIES - 1)) begin
						next_fail    = 1'b1;
						next_reset_n = 1'b1;
						next_state   = ST_IDLE;
					end else begin
						next_tries   = tries + 1'b1;
						next_reset_n = 1'b1;                       // R11
						next_timer   = TW'(isp_pkg::RST_PULSE_CYC - 1);
						next_state   = ST_PULSE;
					end
				end
			end
			ST_PULSE: begin
				// target released for the retry pulse, sck still low
				if (timer == '0) begin
					next_reset_n = 1'b0;                           // R11
					next_timer   = TW'(POWERUP_WAIT - 1);
					next_state   = ST_POWER;
				end else begin
					next_timer = timer - 1'b1;
				end
			end
			ST_READY: begin
				if (session_end) begin
					next_reset_n = 1'b1;                           // R20
					next_active  = 1'b0;
					next_state   = ST_IDLE;
				end else if (fifo_valid) begin
					// only reached once enable echoed; reset still low
					fifo_ready     = 1'b1;                         // R2
					shift_start    = 1'b1;                         // R1
					// words go out verbatim: page loads, page commits, erase
					shift_word     = fifo_data[isp_pkg::INSTR_BITS-1:0]; // R12 R14 R17 R23
					next_wait_kind = isp_pkg::wait_e'(
						fifo_data[isp_pkg::FIFO_WIDTH-1 -: isp_pkg::WAIT_W]);
					next_state     = ST_SEND;
				end
			end
			ST_SEND: begin
				if (shift_done) begin
					next_rsp_valid = 1'b1;
					next_rsp_word  = shift_rx;                     // R19
					if (wait_kind == isp_pkg::WAIT_NONE) begin
						next_state = ST_READY;
					end else begin
						// hold off the port until the self-timed write ends
						next_timer = wait_cycles(wait_kind) - 1'b1; // R25
						next_state = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				// no busy polling: the fixed wait covers the worst case
				if (timer == '0) begin
					next_state = ST_READY;
				end else begin
					next_timer = timer - 1'b1;                     // R15
				end
			end
			default: begin
				// illegal code: release the target and start over
				next_reset_n = 1'b1;
				next_active  = 1'b0;
				next_state   = ST_IDLE;
			end
		endcase
	end

	// --------------------------------------------------------------
	// sequencer registers
	// --------------------------------------------------------------
	// state, timers and pin levels; reset keeps the target released
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state          <= ST_IDLE;
			timer          <= '0;
			tries          <= '0;
			wait_kind      <= isp_pkg::WAIT_NONE;
			target_reset_n <= 1'b1;
			session_active <= 1'b0;
			sync_fail      <= 1'b0;
			rsp_valid      <= 1'b0;
			rsp_word       <= '0;
		end else begin
			state          <= next_state;
			timer          <= next_timer;
			tries          <= next_tries;
			wait_kind      <= next_wait_kind;
			target_reset_n <= next_reset_n;
			session_active <= next_active;
			sync_fail      <= next_fail;
			rsp_valid      <= next_rsp_valid;
			rsp_word       <= next_rsp_word;
		end
	end

	// --------------------------------------------------------------
	// link status
	// --------------------------------------------------------------
	// link occupied: power-up, enable, pulse, shift or wait
	// session_start and session_end are only taken while this is low
	assign link_busy = (state != ST_IDLE) && (state != ST_READY);
endmodule : isp_programmer
`default_nettype wire

// ### rtl/isp_shift.sv
`default_nettype none
module isp_shift (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic [31:0] tx_word,
	input  wire logic        miso_level,
	output logic             sck,
	output logic             mosi,
	output logic             done,
	output logic      [31:0] rx_word
);
	localparam logic [4:0] HALF_LAST = 5'(isp_pkg::SCK_HALF_CYC - 1);
	localparam logic [5:0] BIT_LAST  = 6'(isp_pkg::INSTR_BITS);

	logic        busy,   next_busy;
	logic [4:0]  div,    next_div;
	logic [5:0]  bits,   next_bits;
	logic [31:0] sr,     next_sr;
	logic [31:0] rx,     next_rx;
	logic        next_sck, next_mosi, next_done;
	logic        tick;

	// --------------------------------------------------------------
	// half-period divider and bit sequencing
	// --------------------------------------------------------------
	always_comb begin
		tick      = busy && (div == HALF_LAST);
		next_busy = busy;
		next_div  = busy ? (tick ? '0 : div + 1'b1) : '0;
		next_bits = bits;
		next_sr   = sr;
		next_rx   = rx;
		next_sck  = sck;
		next_mosi = mosi;
		next_done = 1'b0;
		if (!busy && start) begin
			next_busy = 1'b1;
			next_bits = '0;
			next_sr   = tx_word << 1;
			next_mosi = tx_word[31];                 // R24
		end else if (tick && !sck) begin
			next_sck  = 1'b1;                        // rising: device samples mosi R6
			next_rx   = {rx[30:0], miso_level};      // device drove on falling R7
			next_bits = bits + 1'b1;
		end else if (tick) begin
			next_sck  = 1'b0;
			next_mosi = sr[31];                      // change mosi on falling edge
			next_sr   = sr << 1;
			if (bits == BIT_LAST) begin
				next_busy = 1'b0;                    // four bytes framed R24
				next_done = 1'b1;
				next_mosi = 1'b0;
			end
		end
	end

	// registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			div  <= '0;
			bits <= '0;
			sr   <= '0;
			rx   <= '0;
			sck  <= 1'b0;
			mosi <= 1'b0;
			done <= 1'b0;
		end else begin
			busy <= next_busy;
			div  <= next_div;
			bits <= next_bits;
			sr   <= next_sr;
			rx   <= next_rx;
			sck  <= next_sck;
			mosi <= next_mosi;
			done <= next_done;
		end
	end

	assign rx_word = rx;
endmodule : isp_shift
`default_nettype wire

// ### shared/isp_pkg.sv
`default_nettype none
package isp_pkg;
	// --------------------------------------------------------------
	// clock and link timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int SCK_HALF_NS   = 1000;
	localparam int RST_PULSE_NS  = 1000;
	localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// --------------------------------------------------------------
	// least wait times, in microseconds, and their cycle counts
	// --------------------------------------------------------------
	localparam int POWERUP_WAIT_US      = 20000;
	localparam int FLASH_PAGE_WAIT_US   = 4500;
	localparam int EEPROM_WRITE_WAIT_US = 9000;
	localparam int FUSE_WRITE_WAIT_US   = 4500;
	localparam int CHIP_ERASE_WAIT_US   = 9000;
	localparam int NS_PER_US            = 1000;
	localparam int POWERUP_WAIT_CYC     =
		(POWERUP_WAIT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLASH_PAGE_WAIT_CYC  =
		(FLASH_PAGE_WAIT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EEPROM_WRITE_WAIT_CYC =
		(EEPROM_WRITE_WAIT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FUSE_WRITE_WAIT_CYC  =
		(FUSE_WRITE_WAIT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CHIP_ERASE_WAIT_CYC  =
		(CHIP_ERASE_WAIT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// --------------------------------------------------------------
	// instruction framing
	// --------------------------------------------------------------
	localparam int          INSTR_BITS   = 32;
	localparam int          BIT_CNT_W    = 6;
	localparam int          TIMER_W      = 20;
	localparam int          TRY_W        = 3;
	localparam int          MAX_TRIES    = 8;
	localparam int          FIFO_DEPTH   = 16;
	localparam logic [31:0] PROG_EN_WORD = 32'hac53_0000;
	localparam logic [7:0]  ECHO_BYTE    = 8'h53;
	localparam int          ECHO_LSB     = 8;

	// --------------------------------------------------------------
	// wait class that follows an instruction
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		WAIT_NONE   = 3'b000,
		WAIT_FLASH  = 3'b001,
		WAIT_EEPROM = 3'b010,
		WAIT_FUSE   = 3'b011,
		WAIT_ERASE  = 3'b100
	} wait_e;
	localparam int WAIT_W     = 3;
	localparam int FIFO_WIDTH = INSTR_BITS + WAIT_W;
endpackage : isp_pkg
`default_nettype wire

// ### testbench/isp_programmer_sva.sv
`default_nettype none
// ------
// port checker for the serial programmer
// ------
module isp_programmer_sva #(
	parameter int POWERUP_WAIT = 50
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic rsp_valid,
	input wire logic session_active,
	input wire logic sync_fail,
	input wire logic link_busy,
	input wire logic target_reset_n,
	input wire logic target_sck,
	input wire logic target_mosi
);
	timeunit 1ns;
	timeprecision 1ns;
	int low_cnt;
	int next_low_cnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// cycles spent with the target held in reset
	always_comb next_low_cnt = target_reset_n ? 0 : low_cnt + 1;
	// register the count
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) low_cnt <= 0;
		else low_cnt <= next_low_cnt;
	end

	sck_in_reset_a: assert property (target_sck |-> !target_reset_n)
		else $error("serial clock runs outside reset");
	active_reset_a: assert property (session_active |-> !target_reset_n)
		else $error("session active with target released");
	idle_sck_a: assert property (!link_busy && !session_active |-> !target_sck)
		else $error("serial clock high while idle");
	sck_high_a: assert property ($rose(target_sck) |-> target_sck[*8])
		else $error("serial clock high phase too short");
	sck_low_a: assert property ($fell(target_sck) |-> !target_sck[*8])
		else $error("serial clock low phase too short");
	mosi_hold_a: assert property (target_sck |-> $stable(target_mosi))
		else $error("data out changed while clock high");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("response flag longer than one cycle");
	rsp_frame_a: assert property (rsp_valid |-> $past(target_sck, 2) && !$past(target_sck))
		else $error("response not right after last falling edge");
	powerup_a: assert property ($rose(target_sck) |-> low_cnt >= POWERUP_WAIT)
		else $error("frame started before power-up wait");
	end_release_a: assert property ($fell(session_active) |-> ##[0:1] target_reset_n)
		else $error("target not released at session end");
	fail_release_a: assert property ($rose(sync_fail) |-> ##[0:1] target_reset_n)
		else $error("target held after sync failure");
endmodule : isp_programmer_sva

bind isp_programmer isp_programmer_sva #(.POWERUP_WAIT(POWERUP_WAIT)) sva_u (
	.ref_clk, .rst_n, .rsp_valid, .session_active, .sync_fail, .link_busy,
	.target_reset_n, .target_sck, .target_mosi
);
`default_nettype wire

// ### testbench/isp_target_model.sv
`default_nettype none
// ------
// target device stand-in on the serial port
// ------
module isp_target_model #(
	parameter int BUSY_NS = 2500
) (
	input  wire logic reset_n,
	input  wire logic sck,
	input  wire logic mosi,
	input  wire logic mute,
	output logic      miso
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  fl[int];
	logic [7:0]  ee[int];
	logic [7:0]  fpb[int];
	logic [7:0]  epb[int];
	logic [31:0] rx;
	logic [7:0]  tx = 8'h00;
	int          nb = 0;
	int          early = 0;
	bit          en = 0;
	longint      busy_to = 0;

	initial miso = 1'b0;

	// unwritten cells read as erased
	function automatic logic [7:0] rd(input bit e, input int a);
		if (e) return ee.exists(a) ? ee[a] : 8'hff;
		return fl.exists(a) ? fl[a] : 8'hff;
	endfunction : rd

	// carry out a complete instruction
	task automatic exec();
		if (rx[31:16] == 16'hac53) en = !mute;
		else if (en && $time >= busy_to) begin
			case (rx[31:24])
				8'hac: begin
					if (rx[23:21] == 3'b100) begin
						fl.delete();
						ee.delete();
					end
					busy_to = $time + BUSY_NS;
				end
				8'h40, 8'h48: fpb[{rx[13:8], rx[27]}] = rx[7:0];
				8'h4c: begin
					foreach (fpb[i]) fl[{rx[23:14], 7'h0} + i] = fpb[i];
					fpb.delete();
					busy_to = $time + BUSY_NS;
				end
				8'hc0: begin
					ee[rx[17:8]] = rx[7:0];
					busy_to = $time + BUSY_NS;
				end
				8'hc1: epb[rx[9:8]] = rx[7:0];
				8'hc2: begin
					foreach (epb[i]) ee[{rx[17:10], 2'b00} + i] = epb[i];
					epb.delete();
					busy_to = $time + BUSY_NS;
				end
				default: ;
			endcase
		end
	endtask : exec

	// any reset edge drops framing and mode
	always @(reset_n) begin
		nb = 0;
		en = 0;
	end

	// sample on the rising edge, frame every 32 bits
	always @(posedge sck) begin
		if (!reset_n) begin
			if ($time < busy_to) early++;
			rx = {rx[30:0], mosi};
			nb++;
			if (nb % 8 == 0) tx = rx[7:0];
			if (nb == 24 && rx[23:16] == 8'ha0) tx = rd(1, rx[9:0]);
			if (nb == 24 && (rx[23:16] & 8'hf7) == 8'h20) tx = rd(0, {rx[15:0], rx[19]});
			if (nb == 32) begin
				exec();
				nb = 0;
			end
		end
	end

	// shift out on the falling edge; a released line toggles
	always @(negedge sck or posedge reset_n) begin
		if (reset_n || mute) miso <= ~miso;
		else begin
			miso <= tx[7];
			tx = {tx[6:0], 1'b0};
		end
	end
endmodule : isp_target_model
`default_nettype wire

// ### testbench/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WAITC = 50;
	logic        ref_clk = 0;
	logic        rst_n = 0;
	logic        session_start = 0;
	logic        session_end = 0;
	logic        cmd_valid = 0;
	logic [31:0] cmd_word = 0;
	logic [2:0]  cmd_wait = 0;
	logic        mute = 0;
	logic        cmd_ready, rsp_valid, session_active, sync_fail, link_busy;
	logic        target_reset_n, target_sck, target_mosi, target_miso;
	logic [31:0] rsp_word;
	logic [23:0] e;
	logic [23:0] exp_q[$];
	logic [7:0]  eem[int];
	logic [7:0]  flm[int];
	int          fail_count = 0;
	int          comparisons = 0;

	// ------
	// design and target
	// ------
	isp_programmer #(.POWERUP_WAIT(WAITC), .FLASH_PAGE_WAIT(WAITC), .EEPROM_WRITE_WAIT(WAITC),
		.FUSE_WRITE_WAIT(WAITC), .CHIP_ERASE_WAIT(WAITC)) dut_u (
		.ref_clk, .rst_n, .session_start, .session_end, .cmd_valid, .cmd_ready, .cmd_word,
		.cmd_wait, .rsp_valid, .rsp_word, .session_active, .sync_fail, .link_busy,
		.target_reset_n, .target_sck, .target_mosi, .target_miso
	);
	isp_target_model #(.BUSY_NS(WAITC * 50)) tgt_u (
		.reset_n(target_reset_n), .sck(target_sck), .mosi(target_mosi), .mute, .miso(target_miso)
	);

	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;

	// ------
	// tasks
	// ------
	task automatic check(input logic [23:0] s, input logic [23:0] x);
		comparisons++;
		if (s !== x) begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, s, x);
		end
	endtask : check

	task automatic print_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict

	// unwritten cells read as erased
	function automatic logic [7:0] mv(input bit ep, input int a);
		if (ep) return eem.exists(a) ? eem[a] : 8'hff;
		return flm.exists(a) ? flm[a] : 8'hff;
	endfunction : mv

	// queue one instruction; d is the byte expected in its last slot
	task automatic op(input logic [31:0] w, input logic [2:0] k, input logic [7:0] d);
		int n;
		exp_q.push_back({w[31:16], d});
		cmd_word  <= w;
		cmd_wait  <= k;
		cmd_valid <= 1'b1;
		n = 0;
		do @(posedge ref_clk); while (cmd_ready !== 1'b1 && n++ < 100000);
	endtask : op

	task automatic wr(input logic [31:0] w, input logic [2:0] k);
		op(w, k, w[15:8]);
	endtask : wr

	task automatic rd(input bit ep, input int a);
		if (ep) op({8'ha0, 6'h0, a[9:0], 8'h00}, isp_pkg::WAIT_NONE, mv(1, a));
		else op({4'h2, a[0], 3'h0, a[16:1], 8'h00}, isp_pkg::WAIT_NONE, mv(0, a));
	endtask : rd

	task automatic stop();
		cmd_valid <= 1'b0;
		@(posedge ref_clk);
	endtask : stop

	task automatic drain();
		int n;
		n = 0;
		while ((exp_q.size() != 0 || link_busy !== 1'b0) && n++ < 60000) @(posedge ref_clk);
		check(24'(n > 60000), 0);
	endtask : drain

	task automatic start_session();
		int n;
		session_start <= 1'b1;
		@(posedge ref_clk);
		session_start <= 1'b0;
		@(posedge ref_clk);
		n = 0;
		while (session_active !== 1'b1 && sync_fail !== 1'b1 && n++ < 20000) @(posedge ref_clk);
	endtask : start_session

	// compare every response with the bench model
	always @(posedge ref_clk) begin
		if (rsp_valid === 1'b1) begin
			e = exp_q.size() != 0 ? exp_q.pop_front() : 'x;
			check(rsp_word[23:0], e);
		end
	end

	// watchdog sized from the expected run of about 60000 cycles
	initial begin
		#(95000 * 50);
		fail_count++;
		print_verdict();
	end

	// ------
	// main sequence
	// ------
	initial begin
		int         a;
		int         p;
		logic [7:0] d;
		void'($urandom(32'h14328327));
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		check({target_reset_n, target_sck, session_active, sync_fail, link_busy, cmd_ready},
			6'b100001);
		$display("test reset done");
		for (int i = 0; i < 16; i++) rd(1, $urandom_range(1023));
		stop();
		check(cmd_ready, 0);
		$display("test queue done");
		mute <= 1'b1;
		start_session();
		check({sync_fail, target_reset_n, session_active}, 3'b110);
		check(24'(exp_q.size()), 16);
		mute <= 1'b0;
		start_session();
		check(session_active, 1);
		drain();
		$display("test sync done");
		a = $urandom_range(1023);
		d = 8'($urandom);
		wr({8'hc0, 6'h0, a[9:0], d}, isp_pkg::WAIT_EEPROM);
		wr({8'hc0, 6'h0, a[9:0], ~d}, isp_pkg::WAIT_EEPROM);
		eem[a] = ~d;
		p = $urandom_range(255);
		wr({8'hc1, 8'h00, 8'h01, d}, isp_pkg::WAIT_NONE);
		wr({8'hc1, 8'h00, 8'h03, ~d}, isp_pkg::WAIT_NONE);
		wr({8'hc2, 6'h0, p[7:6], p[5:0], 2'b00, 8'h00}, isp_pkg::WAIT_EEPROM);
		eem[p * 4 + 1] = d;
		eem[p * 4 + 3] = ~d;
		for (int i = 0; i < 4; i++) rd(1, p * 4 + i);
		rd(1, a);
		$display("test eeprom done");
		a = $urandom_range(65535);
		wr({8'h40, 8'h00, 2'b00, a[5:0], d}, isp_pkg::WAIT_NONE);
		wr({8'h48, 8'h00, 2'b00, a[5:0], ~d}, isp_pkg::WAIT_NONE);
		wr({8'h4c, a[15:8], a[7:6], 6'h0, 8'h00}, isp_pkg::WAIT_FLASH);
		flm[a * 2] = d;
		flm[a * 2 + 1] = ~d;
		rd(0, a * 2);
		rd(0, a * 2 + 1);
		$display("test flash done");
		wr(32'hac80_0000, isp_pkg::WAIT_ERASE);
		eem.delete();
		flm.delete();
		wr(32'haca0_00ff, isp_pkg::WAIT_FUSE);
		rd(1, p * 4 + 1);
		rd(0, a * 2);
		stop();
		drain();
		check(24'(tgt_u.early), 0);
		$display("test erase done");
		session_end <= 1'b1;
		@(posedge ref_clk);
		session_end <= 1'b0;
		@(posedge ref_clk);
		check({target_reset_n, session_active}, 2'b10);
		$display("test end done");
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
